// ### rtl/pin_ctl_pkg.sv
/*
 * shared types and constants for the channel 4/5 register A pin control.
 * assumes a single ref_clk domain, synchronous active-low reset.
 */
package pin_ctl_pkg;

    // =========================================================
    // control field codes
    localparam logic [3:0] CTL_RESET = 4'h0;
    localparam logic [3:0] CTL_OFF_LO = 4'h0;
    localparam logic [3:0] CTL_OFF_HI = 4'h4;
    localparam int CTL_CAPTURE_BIT = 3;
    localparam int CTL_INIT_HI_BIT = 2;
    localparam int CTL_BOTH_BIT = 1;
    localparam int CTL_FALL_BIT = 0;
    localparam int COUNTER_WIDTH = 16;
    localparam int SYNC_STAGES = 3;
    localparam logic PIN_RESET = 1'b0;

    // =========================================================
    // per-channel event carrier
    typedef struct packed {
        logic compare_match;
        logic [COUNTER_WIDTH-1:0] counter;
    } timer_in_t;

    typedef struct packed {
        logic capture_strobe;
        logic [COUNTER_WIDTH-1:0] captured;
    } capture_out_t;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_COMPARE = 2'b01,
        MODE_CAPTURE = 2'b10
    } mode_t;

endpackage

// ### rtl/pin_sync.sv
/*
 * three-flop input synchroniser with agree-on-two filter and edge pulses.
 * assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/1ns
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin_async,
    output logic level_q,
    output logic rise_q,
    output logic fall_q
);
    logic [2:0] sync_q;

    // =========================================================
    // sync chain; stage 0 feeds only stage 1
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            sync_q <= 3'h0;
        else
            sync_q <= {sync_q[1:0], pin_async};
    end

    // level moves only when stages 1 and 2 agree
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if (sync_q[1] == sync_q[2] && sync_q[2] != level_q)
            begin
                level_q <= sync_q[2];
                rise_q <= sync_q[2];
                fall_q <= !sync_q[2];
            end
        end
    end
endmodule

// ### rtl/timer_ch4_ch5_reg_a_pin_control.sv
/*
 * register A pin control for timer channels 4 and 5, plus the buffer-mode
 * override on channel 3 register C. counter, compare match detection and
 * flags live outside; this block drives the pins and produces capture strobes.
 */
// Operation
// - codes 0001-0011 start the pin low then drive low, high or toggle on match.
// - codes 0101-0111 start the pin high then drive low, high or toggle on match.
// - a toggle code inverts the current pin level on every compare match outside the cycle of a code change.
// - code 1000 captures the counter on a rising edge of the channel's own pin.
// - code 1001 captures the counter on a falling edge of the channel's own pin.
// - bit 3 and bit 1 set captures the counter on both pin edges, unless bit 2 is also set on channel 4.
// - on channel 4, codes 11xx capture on channel 3 register A match or capture.
// - on channel 5, bit 2 is ignored when bit 3 is set, so the pin is the source.
// - with buffer mode on channel 3, register C's setting has no effect and no event.
`timescale 1ns/1ns
module timer_ch4_ch5_reg_a_pin_control (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] ch4_ctl,
    input wire logic [3:0] ch5_ctl,
    input wire pin_ctl_pkg::timer_in_t ch4_timer,
    input wire pin_ctl_pkg::timer_in_t ch5_timer,
    input wire logic ch4_io_pin_a_in,
    input wire logic ch5_io_pin_a_in,
    input wire logic ch3_reg_a_event,
    input wire logic buffer_mode_a_select,
    input wire logic ch3_reg_c_event_raw,
    output logic ch4_io_pin_a_out,
    output logic ch4_io_pin_a_oe,
    output logic ch5_io_pin_a_out,
    output logic ch5_io_pin_a_oe,
    output pin_ctl_pkg::capture_out_t ch4_capture,
    output pin_ctl_pkg::capture_out_t ch5_capture,
    output logic ch3_reg_c_event
);
    logic [3:0] ch4_ctl_q;
    logic [3:0] ch5_ctl_q;
    logic ch4_rise;
    logic ch4_fall;
    logic ch5_rise;
    logic ch5_fall;
    logic ch4_trig;
    logic ch5_trig;

    // =========================================================
    // decode helpers
    function automatic logic drives_pin(input logic [3:0] c);
        drives_pin = !c[pin_ctl_pkg::CTL_CAPTURE_BIT] && (c[1:0] != 2'h0);
    endfunction

    function automatic logic next_level(input logic [3:0] c, input logic cur);
        case (c[1:0])
            2'h1: next_level = 1'b0;
            2'h2: next_level = 1'b1;
            2'h3: next_level = !cur;
            default: next_level = cur;
        endcase
    endfunction

    function automatic logic edge_hit(input logic [3:0] c, input logic r, input logic f);
        if (c[pin_ctl_pkg::CTL_BOTH_BIT])
            edge_hit = r || f;
        else if (c[pin_ctl_pkg::CTL_FALL_BIT])
            edge_hit = f;
        else
            edge_hit = r;
    endfunction

    // =========================================================
    // pin synchronisers
    pin_sync u_sync4 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_async(ch4_io_pin_a_in),
        .level_q(),
        .rise_q(ch4_rise),
        .fall_q(ch4_fall)
    );

    pin_sync u_sync5 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_async(ch5_io_pin_a_in),
        .level_q(),
        .rise_q(ch5_rise),
        .fall_q(ch5_fall)
    );

    // =========================================================
    // control field registers; a change of code re-applies the initial level
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ch4_ctl_q <= pin_ctl_pkg::CTL_RESET;
            ch5_ctl_q <= pin_ctl_pkg::CTL_RESET;
        end
        else
        begin
            ch4_ctl_q <= ch4_ctl;
            ch5_ctl_q <= ch5_ctl;
        end
    end

    // =========================================================
    // compare outputs
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ch4_io_pin_a_out <= pin_ctl_pkg::PIN_RESET;
            ch4_io_pin_a_oe <= 1'b0;
        end
        else
        begin
            ch4_io_pin_a_oe <= drives_pin(ch4_ctl);
            if (ch4_ctl != ch4_ctl_q)
                ch4_io_pin_a_out <= ch4_ctl[pin_ctl_pkg::CTL_INIT_HI_BIT];
            else if (drives_pin(ch4_ctl) && ch4_timer.compare_match)
                ch4_io_pin_a_out <= next_level(ch4_ctl, ch4_io_pin_a_out);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ch5_io_pin_a_out <= pin_ctl_pkg::PIN_RESET;
            ch5_io_pin_a_oe <= 1'b0;
        end
        else
        begin
            ch5_io_pin_a_oe <= drives_pin(ch5_ctl);
            if (ch5_ctl != ch5_ctl_q)
                ch5_io_pin_a_out <= ch5_ctl[pin_ctl_pkg::CTL_INIT_HI_BIT];
            else if (drives_pin(ch5_ctl) && ch5_timer.compare_match)
                ch5_io_pin_a_out <= next_level(ch5_ctl, ch5_io_pin_a_out);
        end
    end

    // =========================================================
    // capture triggers
    always_comb
    begin
        ch4_trig = 1'b0;
        if (ch4_ctl[3])
        begin
            if (ch4_ctl[2])
                ch4_trig = ch3_reg_a_event;
            else
                ch4_trig = edge_hit(ch4_ctl, ch4_rise, ch4_fall);
        end
        // bit 2 is not looked at on channel 5
        ch5_trig = ch5_ctl[3] && edge_hit(ch5_ctl, ch5_rise, ch5_fall);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ch4_capture <= '0;
            ch5_capture <= '0;
        end
        else
        begin
            ch4_capture.capture_strobe <= ch4_trig;
            ch5_capture.capture_strobe <= ch5_trig;
            if (ch4_trig)
                ch4_capture.captured <= ch4_timer.counter;
            if (ch5_trig)
                ch5_capture.captured <= ch5_timer.counter;
        end
    end

    // =========================================================
    // channel 3 register C: buffer mode blocks its events
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            ch3_reg_c_event <= 1'b0;
        else
            ch3_reg_c_event <= ch3_reg_c_event_raw && !buffer_mode_a_select;
    end

    // =========================================================
    // checks
    chk_off_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch4_ctl == pin_ctl_pkg::CTL_OFF_HI || ch4_ctl == pin_ctl_pkg::CTL_OFF_LO)
        |=> !ch4_io_pin_a_oe)
        else $error("ch4 pin driven in off code");
    chk_init_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch5_ctl != ch5_ctl_q) |=> (ch5_io_pin_a_out == $past(ch5_ctl[2])))
        else $error("ch5 initial level wrong");
    chk_match_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch4_ctl == ch4_ctl_q && ch4_ctl[3:0] inside {4'h2, 4'h6} && ch4_timer.compare_match)
        |=> ch4_io_pin_a_out)
        else $error("ch4 not high after match");
    chk_toggle_flip: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch5_ctl == ch5_ctl_q && !ch5_ctl[3] && ch5_ctl[1:0] == 2'h3 && ch5_timer.compare_match)
        |=> (ch5_io_pin_a_out != $past(ch5_io_pin_a_out)))
        else $error("ch5 toggle missed");
    chk_rise_cap: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch5_ctl[3] && ch5_ctl[1:0] == 2'h0 && ch5_rise)
        |=> ch5_capture.capture_strobe && ch5_capture.captured == $past(ch5_timer.counter))
        else $error("ch5 rising capture missed");
    chk_fall_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch4_ctl == 4'h9 && ch4_rise) |=> !ch4_capture.capture_strobe)
        else $error("ch4 captured on rise in falling mode");
    chk_both_edges: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch4_ctl[3:1] == 3'h5 && ch4_fall) |=> ch4_capture.capture_strobe)
        else $error("ch4 both-edge capture missed");
    chk_ch3_trigger: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch4_ctl[3:2] == 2'h3) |=> (ch4_capture.capture_strobe == $past(ch3_reg_a_event)))
        else $error("ch4 internal trigger mismatch");
    chk_ch5_pin_src: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ch5_ctl[3:2] == 2'h3 && !ch5_rise && !ch5_fall) |=> !ch5_capture.capture_strobe)
        else $error("ch5 captured without pin edge");
    chk_buffer_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
        buffer_mode_a_select |=> !ch3_reg_c_event)
        else $error("reg c event in buffer mode");

    cov_toggle: cover property (@(posedge ref_clk) disable iff (!rst_b)
        ch4_io_pin_a_oe && $changed(ch4_io_pin_a_out));
    cov_pin_cap: cover property (@(posedge ref_clk) disable iff (!rst_b)
        ch5_capture.capture_strobe);
    cov_int_cap: cover property (@(posedge ref_clk) disable iff (!rst_b)
        ch4_ctl[3:2] == 2'h3 ##1 ch4_capture.capture_strobe);
endmodule

// ### verification/pin_model.sv
/*
 * far-side model of the channel 4 and 5 pin A wires: an external source per pin.
 * assumes the bench asks for levels; the block's drive wins while its oe is high.
 */
`timescale 1ns/1ns
module pin_model (
    input wire logic [1:0] level_req,
    input wire logic [1:0] drv_out,
    input wire logic [1:0] drv_oe,
    output logic [1:0] pin_wire
);
    logic [1:0] src_q = 2'h0;

    // =========================================================
    // source and wire
    // source edges land off the clock grid, as a real async pin would
    always @(level_req) src_q <= #1 level_req;
    assign pin_wire = (drv_oe & drv_out) | (~drv_oe & src_q);
endmodule

// ### verification/tb_top.sv
/*
 * self-checking bench for the channel 4/5 register A pin control.
 * assumes one 250 MHz ref_clk and the pin model on the far side.
 */
`timescale 1ns/1ns
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] ch4_ctl = 4'h0, ch5_ctl = 4'h0;
    pin_ctl_pkg::timer_in_t t4 = '0, t5 = '0;
    logic evt_a = 1'b0, buf_sel = 1'b0, evt_c_raw = 1'b1, evt_c;
    logic [1:0] level_req = 2'h0, pin_wire, drv_out, drv_oe;
    pin_ctl_pkg::capture_out_t cap4, cap5;
    int fails = 0, total_checks = 0, cycles = 0;
    // row: code, oe, initial level, level after first and second match
    logic [7:0] rows [8] = '{8'h00, 8'h18, 8'h2b, 8'h3a, 8'h40, 8'h5c, 8'h6f, 8'h7d};

    always #2 ref_clk = ~ref_clk;

    timer_ch4_ch5_reg_a_pin_control dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .ch4_ctl(ch4_ctl), .ch5_ctl(ch5_ctl), .ch4_timer(t4), .ch5_timer(t5),
        .ch4_io_pin_a_in(pin_wire[0]), .ch5_io_pin_a_in(pin_wire[1]),
        .ch3_reg_a_event(evt_a), .buffer_mode_a_select(buf_sel),
        .ch3_reg_c_event_raw(evt_c_raw), .ch4_io_pin_a_out(drv_out[0]),
        .ch4_io_pin_a_oe(drv_oe[0]), .ch5_io_pin_a_out(drv_out[1]),
        .ch5_io_pin_a_oe(drv_oe[1]), .ch4_capture(cap4), .ch5_capture(cap5),
        .ch3_reg_c_event(evt_c));

    pin_model far_u (.level_req(level_req), .drv_out(drv_out), .drv_oe(drv_oe),
        .pin_wire(pin_wire));

    // =========================================================
    // shared tasks
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pins(input logic oe, input logic lvl);
        check(16'(drv_oe), {14'h0, oe, oe});
        if (oe)
            check(16'(drv_out), {14'h0, lvl, lvl});
    endtask

    task automatic match_pulse;
        @(posedge ref_clk);
        t4.compare_match <= 1'b1;
        t5.compare_match <= 1'b1;
        @(posedge ref_clk);
        t4.compare_match <= 1'b0;
        t5.compare_match <= 1'b0;
        @(negedge ref_clk);
    endtask

    // counter is held across the window so the captured value is known
    task automatic capture(input bit ch, input logic lvl, input bit evt, input logic exp,
        input logic [15:0] cnt);
        logic [15:0] seen;
        seen = 16'h0;
        @(posedge ref_clk);
        t4.counter <= cnt;
        t5.counter <= cnt;
        level_req[ch] <= lvl;
        evt_a <= evt;
        @(posedge ref_clk);
        evt_a <= 1'b0;
        repeat (8)
        begin
            @(negedge ref_clk);
            if ((ch ? cap5.capture_strobe : cap4.capture_strobe) === 1'b1)
                seen = 16'h1;
        end
        check(seen, 16'(exp));
        if (exp)
            check(ch ? cap5.captured : cap4.captured, cnt);
    endtask

    // =========================================================
    // timeout
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            give_verdict();
        end
    end

    // =========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check(16'({drv_oe, cap4.capture_strobe, cap5.capture_strobe, evt_c}), 16'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        evt_c_raw <= 1'b0;
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            ch4_ctl <= rows[i][7:4];
            ch5_ctl <= rows[i][7:4];
            repeat (2) @(negedge ref_clk);
            pins(rows[i][3], rows[i][2]);
            match_pulse();
            pins(rows[i][3], rows[i][1]);
            match_pulse();
            pins(rows[i][3], rows[i][0]);
        end
        // match in the cycle of a code change: the initial level must win
        @(posedge ref_clk);
        ch4_ctl <= 4'h5;
        ch5_ctl <= 4'h5;
        t4.compare_match <= 1'b1;
        t5.compare_match <= 1'b1;
        @(posedge ref_clk);
        t4.compare_match <= 1'b0;
        t5.compare_match <= 1'b0;
        @(negedge ref_clk);
        pins(1'b1, 1'b1);
        @(posedge ref_clk);
        ch4_ctl <= 4'h8;
        ch5_ctl <= 4'h8;
        repeat (10) @(posedge ref_clk);
        capture(1, 1'b1, 0, 1'b1, 16'h1234);
        capture(1, 1'b0, 0, 1'b0, 16'h2345);
        capture(0, 1'b1, 0, 1'b1, 16'h3456);
        @(posedge ref_clk);
        ch5_ctl <= 4'h9;
        capture(1, 1'b1, 0, 1'b0, 16'h4567);
        capture(1, 1'b0, 0, 1'b1, 16'h5678);
        @(posedge ref_clk);
        ch5_ctl <= 4'ha;
        capture(1, 1'b1, 0, 1'b1, 16'h6789);
        capture(1, 1'b0, 0, 1'b1, 16'h789a);
        @(posedge ref_clk);
        ch5_ctl <= 4'hc;
        capture(1, 1'b1, 0, 1'b1, 16'h89ab);
        capture(1, 1'b1, 1, 1'b0, 16'h0f1e);
        @(posedge ref_clk);
        ch4_ctl <= 4'hc;
        capture(0, 1'b0, 0, 1'b0, 16'h9abc);
        capture(0, 1'b0, 1, 1'b1, 16'habcd);
        for (int b = 0; b < 2; b++)
        begin
            @(posedge ref_clk);
            buf_sel <= b[0];
            evt_c_raw <= 1'b1;
            @(posedge ref_clk);
            evt_c_raw <= 1'b0;
            @(negedge ref_clk);
            check(16'(evt_c), 16'(!b[0]));
        end
        // mid-run reset with a compare code waiting: outputs clear, then initial level
        @(posedge ref_clk);
        rst_b <= 1'b0;
        ch4_ctl <= 4'h7;
        ch5_ctl <= 4'h7;
        repeat (2) @(negedge ref_clk);
        check(16'({drv_oe, drv_out, cap4.capture_strobe, cap5.capture_strobe}), 16'h0);
        check(cap5.captured, 16'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge ref_clk);
        pins(1'b1, 1'b1);
        give_verdict();
    end
endmodule
